// ### common/intvec_pkg.sv
package intvec_pkg;

  // ----------------------------------------------------------------
  // Vector window
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_TOP        = 16'hffff;
  localparam logic [15:0] VEC_BASE       = 16'hff80;
  localparam logic [15:0] PERIPH_LIMIT   = 16'h1000;
  localparam int          PRIO_RESET     = 63;
  localparam int          PRIO_SYS_NMI   = 62;
  localparam int          PRIO_USER_NMI  = 61;
  localparam int          PRIO_MASK_TOP  = 60;
  localparam int          PRIO_RESERVED  = 47;
  localparam int          SLOT_RESERVED  = 13;
  localparam int          SLOT_TIMER0_G  = 6;
  localparam int          SLOT_RADIO     = 7;
  localparam int          SLOT_DMA       = 8;
  localparam int          MASK_SLOTS     = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE        = 8'h00;
  localparam logic [7:0] OFS_NMI_EN      = 8'h04;
  localparam logic [7:0] OFS_MASK_EN     = 8'h08;
  localparam logic [7:0] OFS_STATUS      = 8'h0c;
  localparam logic [7:0] OFS_RST_CAUSE   = 8'h10;
  localparam logic [7:0] OFS_SNMI_CAUSE  = 8'h14;
  localparam logic [7:0] OFS_UNMI_CAUSE  = 8'h18;
  localparam logic [7:0] OFS_T0_CAUSE    = 8'h1c;
  localparam logic [7:0] OFS_DMA_CAUSE   = 8'h20;
  localparam logic [7:0] OFS_RIF_CAUSE   = 8'h24;
  localparam logic [7:0] OFS_RCORE_CAUSE = 8'h28;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  RST_FLAGS_INIT = 6'h01;
  localparam logic [6:0]  NMI_EN_INIT    = 7'h00;
  localparam logic [15:0] MASK_EN_INIT   = 16'h0000;

  // ----------------------------------------------------------------
  // Operating modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_ACTIVE            = 6'h01,
    MODE_SLEEP_LEVEL_ZERO  = 6'h02,
    MODE_SLEEP_LEVEL_ONE   = 6'h04,
    MODE_SLEEP_LEVEL_TWO   = 6'h08,
    MODE_SLEEP_LEVEL_THREE = 6'h10,
    MODE_SLEEP_LEVEL_FOUR  = 6'h20
  } mode_t;

  // Clock gates {cpu, main, subsystem, aux, fll, osc_out, osc_dc, xtal}
  localparam logic [7:0] GATES_ACTIVE = 8'hff;
  localparam logic [7:0] GATES_LVL0   = 8'h3f;
  localparam logic [7:0] GATES_LVL1   = 8'h37;
  localparam logic [7:0] GATES_LVL2   = 8'h13;
  localparam logic [7:0] GATES_LVL3   = 8'h11;
  localparam logic [7:0] GATES_LVL4   = 8'h00;

endpackage

// ### core/cause_encoder.sv
`timescale 1ns/100ps
module cause_encoder #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] flags_i,  // Pending flags, bit 0 highest
  output logic      [15:0]  vec_o,    // 2*(index+1), zero when none
  output logic      [W-1:0] first_o   // One-hot of reported flag
);

  // ----------------------------------------------------------------
  // Lowest index wins
  // ----------------------------------------------------------------
  always_comb begin
    vec_o   = 16'h0000;
    first_o = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (flags_i[i]) begin
        vec_o   = 16'((i + 1) * 2);
        first_o = W'(1) << i;
      end
    end
  end

endmodule

// ### core/interrupt_vector_lowpower_ctrl.sv
`timescale 1ns/100ps
// How it works
// - Vectors and start vector lie between top word and base ff80.
// - Every vector slot is one 16-bit handler address word.
// - Reset-class events request a system reset, top vector; power-up loads top vector, no reset pulse.
// - Supervisor, vacant access, mailbox share system NMI, cause vector.
// - External NMI, oscillator fault, flash access share user NMI.
// - NMI sources obey their own enables, ignore global enable.
// - Maskable slots run 60 down to 45, slot 47 reserved.
// - Both radio flag groups share priority 53, each own cause vector.
// - Timer0 channel 0 own vector; channels 1-4 and overflow next.
// - Three DMA channel flags share priority 52 with cause vector.
// - Reserved slots 44 down to 0 are never requested.
// - Instruction fetch from peripheral space forces a system reset.
// - Shared vectors expose which pending source caused the request.
// - Enabled interrupt wakes from sleep; return restores the sleep level.
// - Active mode keeps every clock running.
// - Level zero stops core and main clock only.
// - Level one also stops loop regulation.
// - Level two stops subsystem and oscillator clock, keeps DC generator.
// - Level three also powers down the DC generator.
// - Level four stops every clock and crystal, data retained.
module interrupt_vector_lowpower_ctrl
  import intvec_pkg::*;
(
  input  wire logic        CLK_I,            // System clock
  input  wire logic        SYS_RST_I,        // Async reset, high
  // Wishbone slave
  input  wire logic        CYC_I,            // Bus cycle
  input  wire logic        STB_I,            // Strobe
  input  wire logic        WE_I,             // Write enable
  input  wire logic [7:0]  ADR_I,            // Byte address
  input  wire logic [3:0]  SEL_I,            // Byte lanes
  input  wire logic [31:0] DAT_I,            // Write data
  output logic      [31:0] DAT_O,            // Read data
  output logic             ACK_O,            // Acknowledge
  // Event sources
  input  wire logic [4:0]  RST_EVT_I,        // Reset-class event pulses
  input  wire logic [3:0]  SNMI_EVT_I,       // System NMI event pulses
  input  wire logic [2:0]  UNMI_EVT_I,       // User NMI event pulses
  input  wire logic [15:0] IRQ_I,            // Single-flag maskable levels
  input  wire logic [4:0]  TIMER0_FLAGS_I,   // Timer0 ch1-4, overflow
  input  wire logic [2:0]  DMA_FLAGS_I,      // DMA channel complete
  input  wire logic [7:0]  RADIO_IF_FLAGS_I, // Radio interface flags
  input  wire logic [7:0]  RADIO_CORE_FLAGS_I, // Radio core flags
  // Core side
  input  wire logic        GIE_I,            // Global enable
  input  wire logic        FETCH_I,          // Instruction fetch valid
  input  wire logic [15:0] FETCH_ADDR_I,     // Fetch address
  input  wire logic        RETI_I,           // Return from handler pulse
  output logic             INT_REQ_O,        // Interrupt request
  output logic      [15:0] VEC_ADDR_O,       // Vector fetch address
  output logic             SYS_RST_REQ_O,    // System reset pulse
  // Clock gates
  output logic             CPU_EN_O,         // Core run
  output logic             MAIN_CLK_EN_O,    // Main clock
  output logic             SUBSYSTEM_CLOCK_EN_O, // Subsystem clock
  output logic             AUX_CLK_EN_O,     // Auxiliary clock
  output logic             FLL_EN_O,         // Loop regulation
  output logic             OSCILLATOR_OUTPUT_CLOCK_EN_O, // Osc clock
  output logic             OSC_DC_EN_O,      // Osc DC generator
  output logic             XTAL_EN_O         // Crystal oscillator
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        ack_q;
  logic [31:0] rdata_q;
  wire         bus_req  = CYC_I & STB_I & ~ack_q;
  wire         bus_done = CYC_I & STB_I & ack_q;
  wire         wr_done  = bus_done & WE_I & SEL_I[0];
  wire         rd_done  = bus_done & ~WE_I;
  wire         hit_mode = (ADR_I == OFS_MODE);
  wire         hit_nmi  = (ADR_I == OFS_NMI_EN);
  wire         hit_mask = (ADR_I == OFS_MASK_EN);
  wire         hit_rst  = (ADR_I == OFS_RST_CAUSE);
  wire         hit_snmi = (ADR_I == OFS_SNMI_CAUSE);
  wire         hit_unmi = (ADR_I == OFS_UNMI_CAUSE);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [2:0]  mode_sel_q;
  logic [6:0]  nmi_en_q;
  logic [15:0] mask_en_q;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mode_sel_q <= 3'h0;
      nmi_en_q   <= NMI_EN_INIT;
      mask_en_q  <= MASK_EN_INIT;
    end else begin
      if (wr_done && hit_mode)
        mode_sel_q <= (DAT_I[2:0] > 3'h5) ? 3'h5 : DAT_I[2:0];
      if (wr_done && hit_nmi)
        nmi_en_q <= DAT_I[6:0];
      if (wr_done && hit_mask && SEL_I[1])
        mask_en_q <= DAT_I[15:0];
      else if (wr_done && hit_mask)
        mask_en_q <= {mask_en_q[15:8], DAT_I[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // Sticky cause flags
  // ----------------------------------------------------------------
  logic [5:0] rst_flags_q;
  logic [3:0] snmi_flags_q;
  logic [2:0] unmi_flags_q;
  logic       rst_pulse_q;
  logic [15:0] rst_vec, snmi_vec, unmi_vec;
  logic [5:0]  rst_first;
  logic [3:0]  snmi_first;
  logic [2:0]  unmi_first;

  wire fetch_bad = FETCH_I & (FETCH_ADDR_I < PERIPH_LIMIT);
  wire [5:0] rst_set = {fetch_bad, RST_EVT_I};
  wire [5:0] rst_clr = (rd_done && hit_rst) ? rst_first : 6'h00;
  wire [3:0] snmi_clr = (rd_done && hit_snmi) ? snmi_first : 4'h0;
  wire [2:0] unmi_clr = (rd_done && hit_unmi) ? unmi_first : 3'h0;

  // Set wins over a clearing read in the same cycle
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rst_flags_q  <= RST_FLAGS_INIT;
      snmi_flags_q <= 4'h0;
      unmi_flags_q <= 3'h0;
      rst_pulse_q  <= 1'b0;
    end else begin
      rst_flags_q  <= (rst_flags_q & ~rst_clr) | rst_set;
      snmi_flags_q <= (snmi_flags_q & ~snmi_clr) | SNMI_EVT_I;
      unmi_flags_q <= (unmi_flags_q & ~unmi_clr) | UNMI_EVT_I;
      rst_pulse_q  <= |rst_set;
    end
  end

  // ----------------------------------------------------------------
  // Cause vectors
  // ----------------------------------------------------------------
  logic [15:0] t0_vec, dma_vec, rif_vec, rcore_vec;

  cause_encoder #(.W(6)) u_rst_cause (
    .flags_i (rst_flags_q),
    .vec_o   (rst_vec),
    .first_o (rst_first)
  );
  cause_encoder #(.W(4)) u_snmi_cause (
    .flags_i (snmi_flags_q),
    .vec_o   (snmi_vec),
    .first_o (snmi_first)
  );
  cause_encoder #(.W(3)) u_unmi_cause (
    .flags_i (unmi_flags_q),
    .vec_o   (unmi_vec),
    .first_o (unmi_first)
  );
  cause_encoder #(.W(5)) u_t0_cause (
    .flags_i (TIMER0_FLAGS_I),
    .vec_o   (t0_vec),
    .first_o ()
  );
  cause_encoder #(.W(3)) u_dma_cause (
    .flags_i (DMA_FLAGS_I),
    .vec_o   (dma_vec),
    .first_o ()
  );
  // One cause vector per radio group
  cause_encoder #(.W(8)) u_rif_cause (
    .flags_i (RADIO_IF_FLAGS_I),
    .vec_o   (rif_vec),
    .first_o ()
  );
  cause_encoder #(.W(8)) u_rcore_cause (
    .flags_i (RADIO_CORE_FLAGS_I),
    .vec_o   (rcore_vec),
    .first_o ()
  );

  // ----------------------------------------------------------------
  // Priority levels
  // ----------------------------------------------------------------
  logic [MASK_SLOTS-1:0] slot_raw;
  logic [63:0]           pend;

  genvar s;
  generate
    for (s = 0; s < MASK_SLOTS; s++) begin : g_slot
      // Slot s sits at priority 60 - s
      if (s == SLOT_RESERVED) begin : g_res
        assign slot_raw[s] = 1'b0;
      end else if (s == SLOT_TIMER0_G) begin : g_t0
        assign slot_raw[s] = |TIMER0_FLAGS_I;
      end else if (s == SLOT_RADIO) begin : g_rad
        assign slot_raw[s] = |RADIO_IF_FLAGS_I | |RADIO_CORE_FLAGS_I;
      end else if (s == SLOT_DMA) begin : g_dma
        assign slot_raw[s] = |DMA_FLAGS_I;
      end else begin : g_irq
        assign slot_raw[s] = IRQ_I[s];
      end
      assign pend[PRIO_MASK_TOP-s] = slot_raw[s] & mask_en_q[s] & GIE_I;
    end
  endgenerate

  assign pend[PRIO_MASK_TOP-MASK_SLOTS:0] = '0;
  // NMI enables only, global enable ignored
  assign pend[PRIO_SYS_NMI]  = |(snmi_flags_q & nmi_en_q[3:0]);
  assign pend[PRIO_USER_NMI] = |(unmi_flags_q & nmi_en_q[6:4]);
  assign pend[PRIO_RESET]    = rst_pulse_q;

  logic [5:0] top_prio;
  logic       any_int;

  always_comb begin
    top_prio = 6'h00;
    any_int  = 1'b0;
    for (int p = 0; p < 64; p++) begin
      if (pend[p]) begin
        top_prio = 6'(p);
        any_int  = 1'b1;
      end
    end
  end

  wire [15:0] vec_addr_d = VEC_BASE + {9'h000, top_prio, 1'b0};

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  mode_t mode_sw, mode_eff;
  logic  wake_q;

  always_comb begin
    case (mode_sel_q)
      3'h1:    mode_sw = MODE_SLEEP_LEVEL_ZERO;
      3'h2:    mode_sw = MODE_SLEEP_LEVEL_ONE;
      3'h3:    mode_sw = MODE_SLEEP_LEVEL_TWO;
      3'h4:    mode_sw = MODE_SLEEP_LEVEL_THREE;
      3'h5:    mode_sw = MODE_SLEEP_LEVEL_FOUR;
      default: mode_sw = MODE_ACTIVE;
    endcase
  end

  assign mode_eff = wake_q ? MODE_ACTIVE : mode_sw;

  // Wake on request, sleep again on return
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I)
      wake_q <= 1'b0;
    else if (any_int)
      wake_q <= 1'b1;
    else if (RETI_I)
      wake_q <= 1'b0;
  end

  logic [7:0] gates_d;

  always_comb begin
    case (mode_eff)
      MODE_ACTIVE:            gates_d = GATES_ACTIVE;
      MODE_SLEEP_LEVEL_ZERO:  gates_d = GATES_LVL0;
      MODE_SLEEP_LEVEL_ONE:   gates_d = GATES_LVL1;
      MODE_SLEEP_LEVEL_TWO:   gates_d = GATES_LVL2;
      MODE_SLEEP_LEVEL_THREE: gates_d = GATES_LVL3;
      MODE_SLEEP_LEVEL_FOUR:  gates_d = GATES_LVL4;
      default:                gates_d = GATES_ACTIVE;
    endcase
  end

  // ----------------------------------------------------------------
  // Read mux and outputs
  // ----------------------------------------------------------------
  wire [31:0] status_w = {9'h000, wake_q, mode_sel_q, pend[63:61],
                          slot_raw};
  logic [31:0] rdata_d;

  always_comb begin
    if (hit_mode)                rdata_d = {29'h0, mode_sel_q};
    else if (hit_nmi)            rdata_d = {25'h0, nmi_en_q};
    else if (hit_mask)           rdata_d = {16'h0, mask_en_q};
    else if (ADR_I == OFS_STATUS) rdata_d = status_w;
    else if (hit_rst)            rdata_d = {16'h0, rst_vec};
    else if (hit_snmi)           rdata_d = {16'h0, snmi_vec};
    else if (hit_unmi)           rdata_d = {16'h0, unmi_vec};
    else if (ADR_I == OFS_T0_CAUSE) rdata_d = {16'h0, t0_vec};
    else if (ADR_I == OFS_DMA_CAUSE) rdata_d = {16'h0, dma_vec};
    else if (ADR_I == OFS_RIF_CAUSE) rdata_d = {16'h0, rif_vec};
    else if (ADR_I == OFS_RCORE_CAUSE) rdata_d = {16'h0, rcore_vec};
    else                         rdata_d = 32'h0;
  end

  logic        int_req_q, sys_rst_q;
  logic [15:0] vec_q;
  logic [7:0]  gates_q;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0;
      int_req_q <= 1'b0;
      sys_rst_q <= 1'b0;
      vec_q     <= VEC_TOP - 16'h0001;
      gates_q   <= GATES_ACTIVE;
    end else begin
      ack_q     <= bus_req;
      rdata_q   <= bus_req ? rdata_d : 32'h0;
      int_req_q <= any_int & ~pend[PRIO_RESET];
      sys_rst_q <= pend[PRIO_RESET];
      vec_q     <= vec_addr_d;
      gates_q   <= gates_d;
    end
  end

  assign ACK_O                        = ack_q;
  assign DAT_O                        = rdata_q;
  assign INT_REQ_O                    = int_req_q;
  assign SYS_RST_REQ_O                = sys_rst_q;
  assign VEC_ADDR_O                   = vec_q;
  assign {CPU_EN_O, MAIN_CLK_EN_O, SUBSYSTEM_CLOCK_EN_O, AUX_CLK_EN_O,
          FLL_EN_O, OSCILLATOR_OUTPUT_CLOCK_EN_O, OSC_DC_EN_O,
          XTAL_EN_O}                  = gates_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_bad_fetch;
    FETCH_I && (FETCH_ADDR_I < PERIPH_LIMIT);
  endsequence
  sequence s_reset_out;
    ##1 rst_pulse_q ##1 (SYS_RST_REQ_O && VEC_ADDR_O == VEC_TOP - 16'h1);
  endsequence

  property p_window;
    INT_REQ_O |-> (VEC_ADDR_O >= VEC_BASE);
  endproperty
  a_window: assert property (p_window)
    else $error("Vector outside window");

  property p_word;
    INT_REQ_O |-> (VEC_ADDR_O[0] == 1'b0);
  endproperty
  a_word: assert property (p_word)
    else $error("Vector not word aligned");

  property p_fetch_reset;
    s_bad_fetch |-> s_reset_out;
  endproperty
  a_fetch_reset: assert property (p_fetch_reset)
    else $error("Peripheral fetch did not reset");

  property p_rst_evt;
    (|RST_EVT_I) |-> s_reset_out;
  endproperty
  a_rst_evt: assert property (p_rst_evt)
    else $error("Reset event lost");

  property p_nmi_no_gie;
    (!GIE_I && pend[PRIO_SYS_NMI] && !pend[PRIO_RESET]) |=>
      (INT_REQ_O && VEC_ADDR_O == VEC_BASE + 16'd124);
  endproperty
  a_nmi_no_gie: assert property (p_nmi_no_gie)
    else $error("System NMI blocked by global enable");

  property p_gie_masks;
    (!GIE_I && pend[62:61] == 2'b00 && !rst_pulse_q) |=> !INT_REQ_O;
  endproperty
  a_gie_masks: assert property (p_gie_masks)
    else $error("Maskable request with global enable clear");

  property p_reserved;
    INT_REQ_O |-> (VEC_ADDR_O != VEC_BASE + 16'd94) &&
                  (VEC_ADDR_O >= VEC_BASE + 16'd90);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved vector requested");

  property p_wake;
    (any_int && mode_sw != MODE_ACTIVE) |=> ##1 CPU_EN_O[*2];
  endproperty
  a_wake: assert property (p_wake)
    else $error("No wake on interrupt");

  property p_lvl0;
    (mode_eff == MODE_SLEEP_LEVEL_ZERO) |=>
      (!CPU_EN_O && !MAIN_CLK_EN_O && SUBSYSTEM_CLOCK_EN_O && FLL_EN_O);
  endproperty
  a_lvl0: assert property (p_lvl0)
    else $error("Level zero gating wrong");

  property p_lvl4;
    (mode_eff == MODE_SLEEP_LEVEL_FOUR) |=>
      (gates_q == 8'h00 && !AUX_CLK_EN_O && !XTAL_EN_O);
  endproperty
  a_lvl4: assert property (p_lvl4)
    else $error("Level four left a clock running");

endmodule

// ### dv/core_model.sv
`timescale 1ns/100ps
module core_model (
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Async reset
  input  wire logic        int_req_i,    // Request from block
  input  wire logic [15:0] vec_i,        // Vector address
  input  wire logic        ret_cmd_i,    // Return now
  input  wire logic        fetch_cmd_i,  // Fetch now
  input  wire logic [15:0] addr_cmd_i,   // Fetch address
  output logic             reti_o,       // Handler return
  output logic             fetch_o,      // Fetch valid
  output logic      [15:0] fetch_addr_o, // Fetch address
  output logic      [15:0] handler_o     // Last vector taken
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reti_o <= 1'b0;
      fetch_o <= 1'b0;
      fetch_addr_o <= 16'h0000;
      handler_o <= 16'h0000;
    end else begin
      reti_o <= ret_cmd_i;
      fetch_o <= fetch_cmd_i;
      // Idle bus flips, so a stale address never looks valid
      fetch_addr_o <= fetch_cmd_i ? addr_cmd_i : ~fetch_addr_o;
      handler_o <= int_req_i ? vec_i : handler_o;
    end
  end
endmodule

// ### dv/tb.sv
`timescale 1ns/100ps
module tb
  import intvec_pkg::*;
;
  logic CLK_I, SYS_RST_I, CYC_I, STB_I, WE_I, ACK_O, GIE_I, RETI_I;
  logic FETCH_I, INT_REQ_O, SYS_RST_REQ_O, ret_cmd, fetch_cmd;
  logic [7:0] ADR_I, RADIO_IF_FLAGS_I, RADIO_CORE_FLAGS_I, gates;
  logic [3:0] SEL_I, SNMI_EVT_I;
  logic [31:0] DAT_I, DAT_O, rd;
  logic [4:0] RST_EVT_I, TIMER0_FLAGS_I;
  logic [2:0] UNMI_EVT_I, DMA_FLAGS_I;
  logic [15:0] IRQ_I, FETCH_ADDR_I, VEC_ADDR_O, handler;
  logic c0, c1, c2, c3, c4, c5, c6, XTAL_EN;
  logic [7:0] gtab [6] = '{GATES_ACTIVE, GATES_LVL0, GATES_LVL1,
                           GATES_LVL2, GATES_LVL3, GATES_LVL4};
  int num_errors, checked;
  assign gates = {c0, c1, c2, c3, c4, c5, c6, XTAL_EN};

  interrupt_vector_lowpower_ctrl dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .RST_EVT_I(RST_EVT_I), .SNMI_EVT_I(SNMI_EVT_I),
    .UNMI_EVT_I(UNMI_EVT_I), .IRQ_I(IRQ_I),
    .TIMER0_FLAGS_I(TIMER0_FLAGS_I), .DMA_FLAGS_I(DMA_FLAGS_I),
    .RADIO_IF_FLAGS_I(RADIO_IF_FLAGS_I),
    .RADIO_CORE_FLAGS_I(RADIO_CORE_FLAGS_I), .GIE_I(GIE_I),
    .FETCH_I(FETCH_I), .FETCH_ADDR_I(FETCH_ADDR_I), .RETI_I(RETI_I),
    .INT_REQ_O(INT_REQ_O), .VEC_ADDR_O(VEC_ADDR_O),
    .SYS_RST_REQ_O(SYS_RST_REQ_O), .CPU_EN_O(c0), .MAIN_CLK_EN_O(c1),
    .SUBSYSTEM_CLOCK_EN_O(c2), .AUX_CLK_EN_O(c3), .FLL_EN_O(c4),
    .OSCILLATOR_OUTPUT_CLOCK_EN_O(c5), .OSC_DC_EN_O(c6),
    .XTAL_EN_O(XTAL_EN));

  core_model core (.clk_i(CLK_I), .rst_i(SYS_RST_I), .int_req_i(INT_REQ_O),
    .vec_i(VEC_ADDR_O), .ret_cmd_i(ret_cmd), .fetch_cmd_i(fetch_cmd),
    .addr_cmd_i(16'h0800), .reti_o(RETI_I), .fetch_o(FETCH_I),
    .fetch_addr_o(FETCH_ADDR_I), .handler_o(handler));

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= d;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      conclude();
    end
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask

  // Reset pulse may come a few cycles after its cause
  task automatic wait_rst;
    int n;
    n = 0;
    while (SYS_RST_REQ_O !== 1'b1 && n < 10) begin
      @(posedge CLK_I);
      n++;
    end
    if (n >= 10) begin
      chk(32'h0, 32'h1);
      conclude();
    end
    chk(VEC_ADDR_O, 16'hfffe);
  endtask

  // Handler return pulse through the core model, then let gates settle
  task automatic ret;
    ret_cmd <= 1'b1;
    tick(1);
    ret_cmd <= 1'b0;
    tick(3);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {SYS_RST_I, CYC_I, STB_I, WE_I, GIE_I, ret_cmd, fetch_cmd} = 7'h40;
    {ADR_I, DAT_I, RST_EVT_I, SNMI_EVT_I, UNMI_EVT_I} = '0;
    {IRQ_I, TIMER0_FLAGS_I, DMA_FLAGS_I} = '0;
    {RADIO_IF_FLAGS_I, RADIO_CORE_FLAGS_I} = '0;
    SEL_I = 4'hf;
    num_errors = 0;
    checked = 0;
    tick(16);
    chk(VEC_ADDR_O, 16'hfffe);
    chk(gates, GATES_ACTIVE);
    SYS_RST_I <= 1'b0;
    wb(0, OFS_RST_CAUSE, 0);
    chk(rd, 32'h2);
    wb(0, OFS_RST_CAUSE, 0);
    chk(rd, 32'h0);
    wb(0, 8'h3c, 0);
    chk(rd, 32'h0);
    RST_EVT_I <= 5'h04;
    tick(1);
    RST_EVT_I <= 5'h00;
    wait_rst();
    wb(0, OFS_RST_CAUSE, 0);
    chk(rd, 32'h6);
    fetch_cmd <= 1'b1;
    tick(1);
    fetch_cmd <= 1'b0;
    wait_rst();
    wb(0, OFS_RST_CAUSE, 0);
    chk(rd, 32'hc);
    // Reset pulses also set wake; return first so sleep shows
    ret();
    for (int m = 1; m < 6; m++) begin
      wb(1, OFS_MODE, m);
      tick(3);
      chk(gates, gtab[m]);
    end
    wb(1, OFS_MODE, 0);
    tick(3);
    chk(gates, GATES_ACTIVE);
    wb(1, OFS_MODE, 32'h7);
    wb(0, OFS_MODE, 0);
    chk(rd, 32'h5);
    wb(1, OFS_MODE, 0);
    wb(1, OFS_NMI_EN, 32'h7f);
    SNMI_EVT_I <= 4'h2;
    tick(1);
    SNMI_EVT_I <= 4'h0;
    tick(3);
    chk(VEC_ADDR_O, 16'hfffc);
    chk(handler, 16'hfffc);
    wb(0, OFS_SNMI_CAUSE, 0);
    chk(rd, 32'h4);
    UNMI_EVT_I <= 3'h4;
    tick(1);
    UNMI_EVT_I <= 3'h0;
    tick(3);
    chk(VEC_ADDR_O, 16'hfffa);
    wb(0, OFS_UNMI_CAUSE, 0);
    chk(rd, 32'h6);
    wb(1, OFS_NMI_EN, 0);
    SNMI_EVT_I <= 4'h1;
    tick(1);
    SNMI_EVT_I <= 4'h0;
    tick(3);
    chk(INT_REQ_O, 1'b0);
    wb(1, OFS_MASK_EN, 32'hffff);
    GIE_I <= 1'b1;
    for (int s = 0; s < 16; s++) begin
      IRQ_I <= 16'h1 << s;
      tick(3);
      if (s inside {6, 7, 8, 13}) chk(INT_REQ_O, 1'b0);
      else chk(VEC_ADDR_O, 16'hff80 + 2 * (60 - s));
    end
    IRQ_I <= 16'h8001;
    tick(3);
    chk(VEC_ADDR_O, 16'hfff8);
    GIE_I <= 1'b0;
    tick(3);
    chk(INT_REQ_O, 1'b0);
    GIE_I <= 1'b1;
    IRQ_I <= 16'h0;
    TIMER0_FLAGS_I <= 5'h10;
    tick(3);
    chk(VEC_ADDR_O, 16'hffec);
    wb(0, OFS_T0_CAUSE, 0);
    chk(rd, 32'ha);
    TIMER0_FLAGS_I <= 5'h0;
    DMA_FLAGS_I <= 3'h6;
    tick(3);
    chk(VEC_ADDR_O, 16'hffe8);
    wb(0, OFS_DMA_CAUSE, 0);
    chk(rd, 32'h4);
    DMA_FLAGS_I <= 3'h0;
    RADIO_IF_FLAGS_I <= 8'h80;
    RADIO_CORE_FLAGS_I <= 8'h01;
    tick(3);
    chk(VEC_ADDR_O, 16'hffea);
    wb(0, OFS_RIF_CAUSE, 0);
    chk(rd, 32'h10);
    wb(0, OFS_RCORE_CAUSE, 0);
    chk(rd, 32'h2);
    {RADIO_IF_FLAGS_I, RADIO_CORE_FLAGS_I} <= 16'h0;
    wb(1, OFS_MODE, 1);
    // Wake is still set from earlier requests; return to reach sleep
    ret();
    chk(gates, GATES_LVL0);
    IRQ_I <= 16'h1;
    tick(3);
    chk(gates, GATES_ACTIVE);
    wb(0, OFS_STATUS, 0);
    chk(rd, 32'h480001);
    IRQ_I <= 16'h0;
    ret();
    chk(gates, GATES_LVL0);
    conclude();
  end
endmodule
